// File: logic/phy_mode_and_led_select.sv
// PHY speed, duplex and negotiation control register with LED routing
// Contract
// - Negotiation mode off: speed bit sets PHY speed, 1 is 100, 0 is 10.
// - Negotiation mode on: speed from negotiation result, or PHY speed bit if disabled.
// - Negotiation mode off: duplex bit sets PHY duplex, 1 full, 0 half.
// - Negotiation mode on: duplex from negotiation result, or PHY duplex if disabled.
// - PHY negotiates only when both negotiation bits are set; else manual.
// - LED-A select code routes one of seven indications to LED-A pin.
// - LED-B select uses the same encoding to drive LED-B pin.
// - After reset both select fields pick the either-speed link indication.
//
// Design decision made here: the AHB-Lite slave port.
`include "phy_mode_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module phy_mode_and_led_select
	import phy_mode_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic enable_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic neg_result_fast_in,
	input wire logic neg_result_full_in,
	input wire logic link_slow_indication_n_in,
	input wire logic full_duplex_indication_n_in,
	input wire logic activity_indication_n_in,
	input wire logic link_fast_indication_n_in,
	input wire logic receive_indication_n_in,
	input wire logic transmit_indication_n_in,
	output logic phy_speed_fast_out,
	output logic phy_full_duplex_out,
	output logic phy_negotiate_out,
	output logic led_a_pin_n_out,
	output logic led_b_pin_n_out
);
	logic [15:0] receive_phy_mode_control;
	logic [15:0] next_receive_phy_mode_control;
	logic [2:0] phy_shadow;
	logic [2:0] next_phy_shadow;
	bus_state_t bus_state;
	bus_state_t next_bus_state;
	logic [`ADDR_WIDTH-1:0] bus_addr;
	logic [`ADDR_WIDTH-1:0] next_bus_addr;
	logic [31:0] next_hrdata;
	logic next_speed;
	logic next_duplex;
	logic next_negotiate;
	logic [6:0] pin_sync1;
	logic [6:0] pin_sync2;
	logic [6:0] pin_sync3;
	logic [6:0] pin_stable;
	logic [6:0] next_pin_stable;
	logic [6:0] pin_raw;
	logic negotiation_mode_select;
	logic phy_negotiation_enable;
	logic next_led_a;
	logic next_led_b;
	logic next_hreadyout;
	logic next_hresp;
	logic [6:0] next_pin_sync1;
	logic [6:0] next_pin_sync2;
	logic [6:0] next_pin_sync3;
	led_route_if route_a ();
	led_route_if route_b ();

	// Bus: address phase captured, write data applied in the data phase
	always_comb
	begin
		next_bus_state = BUS_IDLE;
		next_bus_addr = bus_addr;
		next_receive_phy_mode_control = receive_phy_mode_control;
		next_phy_shadow = phy_shadow;
		next_hrdata = 32'h0000_0000;
		if (bus_state == BUS_WRITE)
		begin
			if (bus_addr == `MODE_CTRL_ADDR)
			begin
				// Reserved bits are kept at zero whatever is written
				next_receive_phy_mode_control = hwdata_in[15:0] & `MODE_CTRL_WRITABLE;
			end
			else if (bus_addr == `PHY_SHADOW_ADDR)
			begin
				next_phy_shadow = hwdata_in[2:0];
			end
		end
		if (hsel_in && hready_in && htrans_in[1])
		begin
			next_bus_addr = haddr_in[`ADDR_WIDTH-1:0];
			if (hwrite_in)
			begin
				next_bus_state = BUS_WRITE;
			end
			else
			begin
				next_bus_state = BUS_READ;
				if (haddr_in[`ADDR_WIDTH-1:0] == `MODE_CTRL_ADDR)
				begin
					next_hrdata = {16'h0000, receive_phy_mode_control};
				end
				else if (haddr_in[`ADDR_WIDTH-1:0] == `PHY_SHADOW_ADDR)
				begin
					next_hrdata = {29'h0000_0000, phy_shadow};
				end
				else if (haddr_in[`ADDR_WIDTH-1:0] == `MODE_STATUS_ADDR)
				begin
					next_hrdata = {29'h0000_0000, phy_negotiate_out, phy_full_duplex_out,
						phy_speed_fast_out};
				end
			end
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			bus_state <= BUS_IDLE;
			bus_addr <= '0;
			receive_phy_mode_control <= `MODE_CTRL_RESET;
			phy_shadow <= `SHADOW_RESET;
			hrdata_out <= 32'h0000_0000;
		end
		else if (enable_in)
		begin
			bus_state <= next_bus_state;
			bus_addr <= next_bus_addr;
			receive_phy_mode_control <= next_receive_phy_mode_control;
			phy_shadow <= next_phy_shadow;
			hrdata_out <= next_hrdata;
		end
	end

	assign negotiation_mode_select = receive_phy_mode_control[`NEG_MODE_BIT];
	assign phy_negotiation_enable = phy_shadow[`SHADOW_NEG_EN_BIT];

	// PHY mode resolution
	always_comb
	begin
		next_negotiate = negotiation_mode_select && phy_negotiation_enable;
		if (!negotiation_mode_select)
		begin
			next_speed = receive_phy_mode_control[`SPEED_BIT];
			next_duplex = receive_phy_mode_control[`DUPLEX_BIT];
		end
		else if (phy_negotiation_enable)
		begin
			next_speed = neg_result_fast_in;
			next_duplex = neg_result_full_in;
		end
		else
		begin
			next_speed = phy_shadow[`SHADOW_SPEED_BIT];
			next_duplex = phy_shadow[`SHADOW_DUPLEX_BIT];
		end
	end

	// Indication pins: three-stage sync, change accepted when stages 2 and 3 agree
	assign pin_raw = {link_slow_indication_n_in & link_fast_indication_n_in,
		transmit_indication_n_in, receive_indication_n_in, link_fast_indication_n_in,
		activity_indication_n_in, full_duplex_indication_n_in, link_slow_indication_n_in};

	// Synchroniser chain; only stage two reads stage one
	always_comb
	begin
		next_pin_sync1 = pin_raw;
		next_pin_sync2 = pin_sync1;
		next_pin_sync3 = pin_sync2;
	end

	genvar g;
	generate
		for (g = 0; g < `LED_SRC_COUNT; g++)
		begin : gen_filter
			always_comb
			begin
				next_pin_stable[g] = pin_stable[g];
				if (pin_sync2[g] == pin_sync3[g])
				begin
					next_pin_stable[g] = pin_sync3[g];
				end
			end
		end
	endgenerate

	assign route_a.sources = pin_stable;
	assign route_b.sources = pin_stable;
	assign route_a.code = receive_phy_mode_control[`LED_A_LSB+2:`LED_A_LSB];
	assign route_b.code = receive_phy_mode_control[`LED_B_LSB+2:`LED_B_LSB];

	led_route u_route_a (
		.route(route_a.router)
	);

	led_route u_route_b (
		.route(route_b.router)
	);

	// Sources stay active low so the pin goes low when asserted
	assign next_led_a = route_a.led;
	assign next_led_b = route_b.led;

	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			pin_sync1 <= 7'h7F;
			pin_sync2 <= 7'h7F;
			pin_sync3 <= 7'h7F;
			pin_stable <= 7'h7F;
			phy_speed_fast_out <= 1'b0;
			phy_full_duplex_out <= 1'b0;
			phy_negotiate_out <= 1'b0;
			led_a_pin_n_out <= 1'b1;
			led_b_pin_n_out <= 1'b1;
		end
		else if (enable_in)
		begin
			pin_sync1 <= next_pin_sync1;
			pin_sync2 <= next_pin_sync2;
			pin_sync3 <= next_pin_sync3;
			pin_stable <= next_pin_stable;
			phy_speed_fast_out <= next_speed;
			phy_full_duplex_out <= next_duplex;
			phy_negotiate_out <= next_negotiate;
			led_a_pin_n_out <= next_led_a;
			led_b_pin_n_out <= next_led_b;
		end
	end

	// Bus response: no wait states, always OKAY
	always_comb
	begin
		next_hreadyout = 1'b1;
		next_hresp = 1'b0;
	end

	// Response kept in flops so every output leaves a register
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
		else if (enable_in)
		begin
			hreadyout_out <= next_hreadyout;
			hresp_out <= next_hresp;
		end
	end
endmodule // phy_mode_and_led_select
`default_nettype wire

// File: logic/phy_mode_defs.svh
// Offsets, field positions and reset values of the PHY mode and LED select block
`ifndef PHY_MODE_DEFS_SVH
`define PHY_MODE_DEFS_SVH
`define MODE_CTRL_INDEX 4'hA
`define MODE_CTRL_ADDR 8'h28
`define PHY_SHADOW_ADDR 8'h2C
`define MODE_STATUS_ADDR 8'h30
`define ADDR_WIDTH 8
`define MODE_CTRL_RESET 16'h0000
`define MODE_CTRL_WRITABLE 16'h38FC
`define SPEED_BIT 13
`define DUPLEX_BIT 12
`define NEG_MODE_BIT 11
`define LED_A_LSB 5
`define LED_B_LSB 2
`define SHADOW_SPEED_BIT 0
`define SHADOW_DUPLEX_BIT 1
`define SHADOW_NEG_EN_BIT 2
`define SHADOW_RESET 3'h0
`define LED_SRC_COUNT 7
`endif

// File: logic/phy_mode_pkg.sv
// Types shared by the PHY mode and LED select block
package phy_mode_pkg;
	typedef logic [2:0] led_code_t;
	typedef enum {BUS_IDLE, BUS_WRITE, BUS_READ} bus_state_t;
endpackage

// File: logic/led_route_if.sv
// Carrier between the top module and the LED routing modules
`timescale 1ns/1ps
`default_nettype none
interface led_route_if;
	logic [6:0] sources;
	logic [2:0] code;
	logic led;
	modport top (output sources, output code, input led);
	modport router (input sources, input code, output led);
endinterface
`default_nettype wire

// File: logic/led_route.sv
// One LED selector: picks an active-low indication by its three-bit code
`timescale 1ns/1ps
`default_nettype none
module led_route
	import phy_mode_pkg::*;
(
	led_route_if.router route
);
	// Sources: 0 slow link,1 full duplex,2 activity,3 fast link,4 rx,5 tx,6 either link
	always_comb
	begin
		case (route.code)
			3'h0: route.led = route.sources[6];
			3'h2: route.led = route.sources[0];
			3'h3: route.led = route.sources[1];
			3'h4: route.led = route.sources[2];
			3'h5: route.led = route.sources[3];
			3'h6: route.led = route.sources[4];
			3'h7: route.led = route.sources[5];
			default: route.led = 1'b1;
		endcase
	end
endmodule // led_route
`default_nettype wire

// File: test/phy_far_model.sv
// Far side model: indication sources and negotiation outcome
`timescale 1ns/1ps
`default_nettype none
module phy_far_model (
	input wire logic clock_in,
	input wire logic [7:0] plan_in,
	output logic [5:0] ind_n_out = 6'h3F,
	output logic [1:0] result_out = 2'h3
);
	// Sources change just after an edge, like the real PHY logic
	always_ff @(posedge clock_in)
		{result_out, ind_n_out} <= plan_in;
endmodule // phy_far_model
`default_nettype wire

// File: test/phy_mode_chk.sv
// Port checker for the PHY mode and LED select block
`timescale 1ns/1ps
`default_nettype none
module phy_mode_chk (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic enable_in,
	input wire logic hsel_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic hready_in,
	input wire logic [31:0] hrdata_out,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	input wire logic neg_result_fast_in,
	input wire logic neg_result_full_in,
	input wire logic link_slow_indication_n_in,
	input wire logic full_duplex_indication_n_in,
	input wire logic activity_indication_n_in,
	input wire logic link_fast_indication_n_in,
	input wire logic receive_indication_n_in,
	input wire logic transmit_indication_n_in,
	input wire logic phy_speed_fast_out,
	input wire logic phy_full_duplex_out,
	input wire logic phy_negotiate_out,
	input wire logic led_a_pin_n_out,
	input wire logic led_b_pin_n_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	logic rd;
	logic all_off;
	logic [2:0] quiet;
	assign rd = hsel_in && hready_in && htrans_in[1] && !hwrite_in && enable_in;
	assign all_off = &{link_slow_indication_n_in, full_duplex_indication_n_in,
		activity_indication_n_in, link_fast_indication_n_in, receive_indication_n_in,
		transmit_indication_n_in};
	// Cycles with every indication released
	always_ff @(posedge clock_in)
		quiet <= (!rst_n_in || !all_off) ? 3'h0 : (enable_in && quiet != 3'h7) ? quiet + 3'h1 : quiet;
	a_ready_always: assert property (hreadyout_out) else $error("hreadyout low");
	a_resp_okay: assert property (!hresp_out) else $error("hresp not okay");
	a_leds_idle_off: assert property (quiet == 3'h7 |-> led_a_pin_n_out && led_b_pin_n_out)
		else $error("led lit without indication");
	a_neg_speed: assert property (phy_negotiate_out && $past(enable_in)
		|-> phy_speed_fast_out == $past(neg_result_fast_in)) else $error("speed not negotiated");
	a_neg_duplex: assert property (phy_negotiate_out && $past(enable_in)
		|-> phy_full_duplex_out == $past(neg_result_full_in)) else $error("duplex not negotiated");
	a_rdata_idle: assert property ($past(enable_in) && !$past(rd) |-> hrdata_out == 32'h0)
		else $error("read data outside read");
	a_freeze_phy: assert property (!enable_in
		|=> $stable({phy_speed_fast_out, phy_full_duplex_out, phy_negotiate_out}))
		else $error("phy outputs moved while frozen");
	a_freeze_leds: assert property (!enable_in |=> $stable({led_a_pin_n_out, led_b_pin_n_out}))
		else $error("led moved while frozen");
endmodule // phy_mode_chk
bind phy_mode_and_led_select phy_mode_chk phy_mode_chk_i (.*);
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the PHY mode and LED select block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic ready, fast, full, nego, led_a, led_b, f, u;
	logic [1:0] htrans = 2'h0, res;
	logic [5:0] ind;
	logic [4:0] x;
	logic [7:0] plan = 8'hFE;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	int fail_count = 0, checks = 0, c, s;
	initial forever #5 clk = ~clk;
	phy_far_model phy_far_model_i (.clock_in(clk), .plan_in(plan), .ind_n_out(ind),
		.result_out(res));
	phy_mode_and_led_select phy_mode_and_led_select_i (.clock_in(clk), .rst_n_in(rst_n),
		.enable_in(en), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(ready), .hrdata_out(hrdata),
		.hreadyout_out(ready), .hresp_out(), .neg_result_fast_in(res[1]),
		.neg_result_full_in(res[0]), .link_slow_indication_n_in(ind[0]),
		.full_duplex_indication_n_in(ind[1]), .activity_indication_n_in(ind[2]),
		.link_fast_indication_n_in(ind[3]), .receive_indication_n_in(ind[4]),
		.transmit_indication_n_in(ind[5]), .phy_speed_fast_out(fast),
		.phy_full_duplex_out(full), .phy_negotiate_out(nego), .led_a_pin_n_out(led_a),
		.led_b_pin_n_out(led_b));
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// One single transfer; read data lands in q
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (ready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (ready !== 1'b1);
		q = hrdata;
	endtask
	function automatic logic led(input int k, input logic [5:0] v);
		return k == 0 ? v[0] & v[3] : k == 1 ? 1'b1 : v[k - 2];
	endfunction
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge clk);
		fail_count++;
		end_of_test;
	end
	initial
	begin
		void'($urandom(32'h7CD1));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, 8'h28, 32'h0);
		cmp("control", 32'h0, q);
		repeat (8) @(posedge clk);
		#1;
		cmp("pins", 5'h00, {fast, full, nego, led_a, led_b});
		$display("test reset done");
		bus(1'b1, 8'h28, 32'hFFFFFFFF);
		bus(1'b0, 8'h28, 32'h0);
		cmp("control", 32'h38FC, q);
		bus(1'b1, 8'h3C, 32'hFFFFFFFF);
		bus(1'b0, 8'h3C, 32'h0);
		cmp("unmapped", 32'h0, q);
		$display("test reserved done");
		for (int i = 0; i < 24; i++)
		begin
			c = $urandom & 32'h3800 | (i % 8) << 5 | (i + 3) % 8 << 2;
			s = $urandom % 8;
			plan <= (i % 4 != 0) ? 8'($urandom) : 8'hFF;
			bus(1'b1, 8'h28, c);
			bus(1'b1, 8'h2C, s);
			en <= 1'b0;
			repeat (2) @(posedge clk);
			en <= 1'b1;
			repeat (8) @(posedge clk);
			#1;
			f = c[11] ? (s[2] ? plan[7] : s[0]) : c[13];
			u = c[11] ? (s[2] ? plan[6] : s[1]) : c[12];
			x = {f, u, c[11] & s[2], led(c >> 5 & 7, plan[5:0]), led(c >> 2 & 7, plan[5:0])};
			cmp("pins", x, {fast, full, nego, led_a, led_b});
			bus(1'b0, 8'h30, 32'h0);
			cmp("status", {x[2], x[3], x[4]}, q);
			bus(1'b0, 8'h28, 32'h0);
			cmp("control", c, q);
		end
		$display("test modes done");
		end_of_test;
	end
endmodule // testbench
`default_nettype wire
